// [design/warning_lamp_decoder.sv]
// warning lamp decoder: network status fields to dashboard lamps and prompt
`timescale 1ns/10ps
module warning_lamp_decoder
    import lamp_pkg::*;
#(
    parameter int SELFTEST_LEN = SELFTEST_CYCLES,
    parameter int LOSS_LEN = LOSS_CYCLES,
    parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] power_state,
    input wire logic vehicle_controller_message,
    input wire vehicle_fields_s vehicle_fields,
    input wire logic battery_message,
    input wire battery_fields_s battery_fields,
    input wire logic telematics_message,
    input wire telematics_fields_s telematics_fields,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output lamps_s lamps,
    output logic prompt_request
);

    // =========================================================
    // register bus slave
    logic waitrequest_q;
    logic [31:0] readdata_q;
    logic [1:0] ctrl_q;
    logic [TIMER_W-1:0] flash_half_q;
    logic [31:0] status_word;
    lamps_s lamps_q;
    logic [UNITS-1:0] lost_q;
    logic selftest_q;
    logic prompt_q;

    // status: [7:0] lamps, [10:8] lost, [12:11] power state, [13] self-test
    assign status_word = {18'h0, selftest_q, power_state, lost_q, lamps_q};

    // one wait cycle, then a single-cycle answer with waitrequest low
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest_q <= 1'b1;
        end else if (waitrequest_q && (read || write)) begin
            waitrequest_q <= 1'b0;
        end else begin
            waitrequest_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readdata_q <= 32'h0;
        end else if (waitrequest_q && read) begin
            case (address)
                CTRL_OFFSET: readdata_q <= {30'h0, ctrl_q};
                FLASH_OFFSET: readdata_q <= {{(32-TIMER_W){1'b0}}, flash_half_q};
                STATUS_OFFSET: readdata_q <= status_word;
                default: readdata_q <= 32'h0;
            endcase
        end
    end

    // writes land on the edge where the master sees waitrequest low
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
            flash_half_q <= TIMER_W'(FLASH_HALF);
        end else if (write && !waitrequest_q) begin
            if (address == CTRL_OFFSET) begin
                ctrl_q <= writedata[1:0];
            end
            // a zero half period would stall the flash; keep the old value
            if (address == FLASH_OFFSET && writedata[TIMER_W-1:0] != '0) begin
                flash_half_q <= writedata[TIMER_W-1:0];
            end
        end
    end

    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;

    // =========================================================
    // message loss supervision
    logic [TIMER_W-1:0] silence_q [UNITS];
    logic [UNITS-1:0] arrived;

    assign arrived = {telematics_message, battery_message, vehicle_controller_message};

    // a fresh message clears loss in the same edge; silence counts up to the limit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < UNITS; i++) begin
                silence_q[i] <= '0;
            end
            lost_q <= '0;
        end else begin
            for (int i = 0; i < UNITS; i++) begin
                if (arrived[i]) begin
                    silence_q[i] <= '0;
                    lost_q[i] <= 1'b0;
                end else if (silence_q[i] >= TIMER_W'(LOSS_LEN - 1)) begin
                    lost_q[i] <= 1'b1;
                end else begin
                    silence_q[i] <= silence_q[i] + 1'b1;
                end
            end
        end
    end

    // =========================================================
    // latest received fields
    // fields only change on their own message pulse, so a lost unit keeps its
    // last values; the loss defaults below override them where required
    vehicle_fields_s vehicle_q;
    battery_fields_s battery_q;
    telematics_fields_s telematics_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            vehicle_q <= '0;
            battery_q <= '0;
            telematics_q <= '0;
        end else begin
            if (vehicle_controller_message) begin
                vehicle_q <= vehicle_fields;
            end
            if (battery_message) begin
                battery_q <= battery_fields;
            end
            if (telematics_message) begin
                telematics_q <= telematics_fields;
            end
        end
    end

    // =========================================================
    // power state tracking and instrument self-test
    power_state_e state_now;
    logic [1:0] state_prev_q;
    logic ignition;
    logic entering_ignition;
    logic [TIMER_W-1:0] selftest_cnt_q;
    logic ready_field_live;

    assign state_now = power_state_e'(power_state);
    assign ignition = state_now == IGNITION_ON_STATE;
    // reset leaves the previous state low-power, so power-up straight into
    // ignition-on also runs the self-test
    assign entering_ignition = ignition &&
        (state_prev_q == LOW_POWER_STATE_A || state_prev_q == LOW_POWER_STATE_B);
    assign ready_field_live = vehicle_q.drive_ready_lamp_state && !lost_q[UNIT_VEHICLE];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_prev_q <= LOW_POWER_STATE_A;
        end else begin
            state_prev_q <= power_state;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            selftest_q <= 1'b0;
            selftest_cnt_q <= '0;
        end else if (entering_ignition) begin
            selftest_q <= 1'b1;
            selftest_cnt_q <= '0;
        end else if (selftest_q) begin
            if (!ignition || ready_field_live) begin
                selftest_q <= 1'b0;
            end else if (selftest_cnt_q >= TIMER_W'(SELFTEST_LEN - 1)) begin
                selftest_q <= 1'b0;
            end else begin
                selftest_cnt_q <= selftest_cnt_q + 1'b1;
            end
        end
    end

    // =========================================================
    // flash generator, 50 percent duty
    // free running: a lamp entering flash may start mid phase, which is harmless
    logic [TIMER_W-1:0] flash_cnt_q;
    logic flash_phase_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flash_cnt_q <= '0;
            flash_phase_q <= 1'b1;
        end else if (flash_cnt_q >= flash_half_q - 1'b1) begin
            flash_cnt_q <= '0;
            flash_phase_q <= !flash_phase_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    // =========================================================
    // lamp decode
    lamps_s lamps_d;
    logic insulation_decoded;
    logic vehicle_lost;

    assign vehicle_lost = lost_q[UNIT_VEHICLE];

    always_comb begin
        if (battery_q.insulation_supervision_state == INSUL_OFF) begin
            insulation_decoded = 1'b0;
        end else if (battery_q.insulation_supervision_state <= INSUL_ON_MAX) begin
            insulation_decoded = 1'b1;
        end else if (battery_q.insulation_supervision_state == INSUL_FLASH) begin
            insulation_decoded = flash_phase_q;
        end else begin
            insulation_decoded = 1'b0;
        end
    end

    // loss defaults take priority over stale fields; self-test only lights lamps
    // that have one, the rest follow their fields from the first cycle
    always_comb begin
        lamps_d = '0;
        if (ignition) begin
            lamps_d.battery_fault = vehicle_lost || vehicle_q.battery_fault;
            if (selftest_q) begin
                lamps_d.insulation = 1'b1;
            end else begin
                lamps_d.insulation = lost_q[UNIT_BATTERY] || insulation_decoded;
            end
            if (vehicle_lost) begin
                lamps_d.drive_ready = 1'b0;
            end else begin
                lamps_d.drive_ready = selftest_q || vehicle_q.drive_ready_lamp_state;
            end
            lamps_d.overheat = vehicle_lost || vehicle_q.overheat;
            lamps_d.system_fault = vehicle_lost ||
                vehicle_q.vehicle_system_fault_lamp_state;
            if (selftest_q) begin
                lamps_d.telematics_fault_lamp = 1'b1;
            end else begin
                lamps_d.telematics_fault_lamp = lost_q[UNIT_TELEMATICS] ||
                    telematics_q.telematics_cellular_state ||
                    telematics_q.telematics_positioning_state ||
                    telematics_q.telematics_power_state;
            end
            lamps_d.battery_service = !vehicle_lost &&
                vehicle_q.battery_service_lamp_state;
        end
        // the cable lamp also works in both low-power states; only code 10 lights it, 00, 01 and 11 stay dark
        if (state_now != POWER_OFF) begin
            lamps_d.charge_cable = battery_q.charge_cable_lamp_state == CABLE_ON;
        end
        // all other lamps stay at zero outside ignition-on
        // software lamp enable darkens every lamp, loss defaults included
        if (!ctrl_q[CTRL_LAMP_EN_BIT]) begin
            lamps_d = '0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lamps_q <= '0;
        end else begin
            lamps_q <= lamps_d;
        end
    end

    assign lamps = lamps_q;

    // =========================================================
    // audible prompt on first ready after reset and after each entry into ignition-on from a low-power state
    // the done flag survives low-power states, so only a fresh entry re-arms it
    logic prompt_done_q;
    logic ready_now;

    // the self-test lighting of the ready lamp does not count as ready
    assign ready_now = ignition && ready_field_live;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prompt_done_q <= 1'b0;
            prompt_q <= 1'b0;
        end else begin
            prompt_q <= 1'b0;
            if (entering_ignition) begin
                prompt_done_q <= 1'b0;
            end else if (ready_now && !prompt_done_q) begin
                prompt_done_q <= 1'b1;
                prompt_q <= ctrl_q[CTRL_PROMPT_EN_BIT];
            end
        end
    end

    assign prompt_request = prompt_q;

endmodule

// [design/lamp_pkg.sv]
// shared constants, types and register map of the warning lamp decoder
package lamp_pkg;

    // =========================================================
    // timing
    localparam int CLOCK_HZ = 20000000;
    localparam int SELFTEST_MS = 3000;
    localparam int LOSS_MS = 2500;
    localparam int FLASH_HZ = 2;
    localparam int SELFTEST_CYCLES = (CLOCK_HZ / 1000) * SELFTEST_MS;
    localparam int LOSS_CYCLES = (CLOCK_HZ / 1000) * LOSS_MS;
    localparam int FLASH_HALF_CYCLES = CLOCK_HZ / (2 * FLASH_HZ);
    localparam int TIMER_W = 27;
    localparam int UNITS = 3;
    localparam int UNIT_VEHICLE = 0;
    localparam int UNIT_BATTERY = 1;
    localparam int UNIT_TELEMATICS = 2;

    // =========================================================
    // register map (byte addresses)
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] FLASH_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    localparam int CTRL_LAMP_EN_BIT = 0;
    localparam int CTRL_PROMPT_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // =========================================================
    // encodings
    typedef enum logic [1:0] {
        POWER_OFF = 2'b00,
        IGNITION_ON_STATE = 2'b01,
        LOW_POWER_STATE_A = 2'b10,
        LOW_POWER_STATE_B = 2'b11
    } power_state_e;

    localparam logic [2:0] INSUL_OFF = 3'h0;
    localparam logic [2:0] INSUL_ON_MAX = 3'h3;
    localparam logic [2:0] INSUL_FLASH = 3'h4;
    localparam logic [1:0] CABLE_ON = 2'h2;

    typedef struct packed {
        logic battery_fault;
        logic drive_ready_lamp_state;
        logic overheat;
        logic vehicle_system_fault_lamp_state;
        logic battery_service_lamp_state;
    } vehicle_fields_s;

    typedef struct packed {
        logic [2:0] insulation_supervision_state;
        logic [1:0] charge_cable_lamp_state;
    } battery_fields_s;

    typedef struct packed {
        logic telematics_cellular_state;
        logic telematics_positioning_state;
        logic telematics_power_state;
    } telematics_fields_s;

    typedef struct packed {
        logic battery_fault;
        logic insulation;
        logic charge_cable;
        logic drive_ready;
        logic overheat;
        logic system_fault;
        logic telematics_fault_lamp;
        logic battery_service;
    } lamps_s;

endpackage

// [dv/lamp_partner.sv]
// remote unit model: periodic status messages from three units
`timescale 1ns/10ps
module lamp_partner
    import lamp_pkg::*;
#(
    parameter int PER = 10
) (
    input wire logic clock,
    input wire logic [2:0] quiet,
    input wire vehicle_fields_s vf,
    input wire battery_fields_s bf,
    input wire telematics_fields_s tf,
    output logic vm,
    output logic bm,
    output logic tm,
    output vehicle_fields_s vo,
    output battery_fields_s bo,
    output telematics_fields_s to
);
    // =====================================
    // staggered sends; fields inverted between pulses so stale data never passes as valid
    int n_q = 0;
    always @(posedge clock) begin
        n_q <= (n_q == PER - 1) ? 0 : n_q + 1;
        vm <= n_q == 0 && !quiet[0];
        bm <= n_q == 3 && !quiet[1];
        tm <= n_q == 6 && !quiet[2];
        vo <= (n_q == 0) ? vf : vehicle_fields_s'(~vf);
        bo <= (n_q == 3) ? bf : battery_fields_s'(~bf);
        to <= (n_q == 6) ? tf : telematics_fields_s'(~tf);
    end
endmodule

// [dv/warning_lamp_decoder_asserts.sv]
// assertion checker for the warning lamp decoder
`timescale 1ns/10ps
module lamp_chk
    import lamp_pkg::*;
#(
    parameter int LOSS_LEN = 30
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] power_state,
    input wire logic vehicle_controller_message,
    input wire vehicle_fields_s vehicle_fields,
    input wire logic battery_message,
    input wire battery_fields_s battery_fields,
    input wire logic telematics_message,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire lamps_s lamps,
    input wire logic prompt_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // =====================================
    // cycles since each unit last spoke; +3 margin covers the +-1 loss edge and lamp register
    int quiet_q [3];
    logic ign;
    assign ign = power_state == 2'b01;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            quiet_q <= '{0, 0, 0};
        end else begin
            quiet_q[0] <= vehicle_controller_message ? 0 : quiet_q[0] + 1;
            quiet_q[1] <= battery_message ? 0 : quiet_q[1] + 1;
            quiet_q[2] <= telematics_message ? 0 : quiet_q[2] + 1;
        end
    end
    // =====================================
    // properties
    chk_vehicle_follow: assert property (
        vehicle_controller_message ##1 (!vehicle_controller_message && ign)[*2] |->
        {lamps.battery_fault, lamps.overheat, lamps.system_fault, lamps.battery_service}
        == $past({vehicle_fields[4], vehicle_fields[2:0]}, 2)) else $error("vehicle lamps");
    chk_cable_follow: assert property (
        battery_message ##1 (!battery_message && power_state != 2'b00)[*2] |->
        lamps.charge_cable == ($past(battery_fields[1:0], 2) == CABLE_ON))
        else $error("cable lamp");
    chk_off_dark: assert property (
        power_state == 2'b00 ##1 power_state == 2'b00 |-> lamps == '0) else $error("off lamps");
    chk_low_dark: assert property (
        power_state[1] ##1 power_state[1] |-> (8'(lamps) & 8'hDF) == 8'h00)
        else $error("low power lamps");
    chk_prompt_once: assert property (
        prompt_request |-> $past(power_state) == 2'b01 ##1 !prompt_request)
        else $error("prompt pulse");
    chk_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest) else $error("bus answer");
    chk_vehicle_loss: assert property (
        quiet_q[0] >= LOSS_LEN + 3 && ign && $past(ign) |->
        lamps.battery_fault && lamps.overheat && lamps.system_fault && !lamps.battery_service)
        else $error("vehicle loss");
    chk_insul_loss: assert property (
        quiet_q[1] >= LOSS_LEN + 3 && ign && $past(ign) |-> lamps.insulation)
        else $error("battery loss");
    chk_tele_loss: assert property (
        quiet_q[2] >= LOSS_LEN + 3 && ign && $past(ign) |-> lamps.telematics_fault_lamp)
        else $error("telematics loss");
endmodule
bind warning_lamp_decoder lamp_chk #(.LOSS_LEN(LOSS_LEN)) i_lamp_chk (
    .clock(clock), .reset_n(reset_n), .power_state(power_state),
    .vehicle_controller_message(vehicle_controller_message), .vehicle_fields(vehicle_fields),
    .battery_message(battery_message), .battery_fields(battery_fields),
    .telematics_message(telematics_message), .read(read), .write(write),
    .waitrequest(waitrequest), .lamps(lamps), .prompt_request(prompt_request));

// [dv/warning_lamp_decoder_tb.sv]
// self-checking testbench for the warning lamp decoder
`timescale 1ns/10ps
module warning_lamp_decoder_tb
    import lamp_pkg::*;
;
    localparam int ST = 40;
    localparam int LOSS = 30;
    logic clock = 0, reset_n = 0, read = 0, write = 0, waitrequest, prompt_request, vm, bm, tm;
    logic [1:0] ps = 2'b10;
    logic [2:0] quiet = 3'h0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q;
    vehicle_fields_s vf = '0, vo;
    battery_fields_s bf = '0, bo;
    telematics_fields_s tf = '0, to;
    lamps_s lamps;
    lamps_s exp_q[$];
    int n_errors = 0, n_tests = 0, n_prompt = 0, cnt;
    event look;

    warning_lamp_decoder #(.SELFTEST_LEN(ST), .LOSS_LEN(LOSS), .FLASH_HALF(4)) i_warning_lamp_decoder (
        .clock(clock), .reset_n(reset_n), .power_state(ps), .vehicle_controller_message(vm),
        .vehicle_fields(vo), .battery_message(bm), .battery_fields(bo), .telematics_message(tm),
        .telematics_fields(to), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .lamps(lamps),
        .prompt_request(prompt_request));
    lamp_partner #(.PER(10)) i_lamp_partner (.clock(clock), .quiet(quiet), .vf(vf), .bf(bf),
        .tf(tf), .vm(vm), .bm(bm), .tm(tm), .vo(vo), .bo(bo), .to(to));

    // =====================================
    // helpers
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        read <= !we;
        write <= we;
        address <= a;
        writedata <= d;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // lamp expectation from the fields last handed to the partner; flash code kept out
    function automatic lamps_s model(input logic [2:0] lost, input logic st);
        logic on;
        lamps_s m;
        on = ps == 2'b01;
        m = '0;
        m.charge_cable = ps != 2'b00 && bf[1:0] == CABLE_ON;
        m.battery_fault = on && (vf[4] || lost[0]);
        m.drive_ready = on && ((vf[3] && !lost[0]) || st);
        m.overheat = on && (vf[2] || lost[0]);
        m.system_fault = on && (vf[1] || lost[0]);
        m.battery_service = on && vf[0] && !lost[0];
        m.insulation = on && (lost[1] || st || (bf[4:2] != 0 && bf[4:2] <= INSUL_ON_MAX));
        m.telematics_fault_lamp = on && (lost[2] || st || (|tf));
        return m;
    endfunction
    task automatic expect_lamps(input lamps_s e);
        exp_q.push_back(e);
        -> look;
    endtask
    always @(look) begin
        chk(lamps, exp_q.pop_front());
    end
    always @(posedge clock) begin
        if (prompt_request === 1'b1) n_prompt++;
    end
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        tick(3000);
        n_errors++;
        final_report();
    end

    // =====================================
    // scenarios
    initial begin
        void'($urandom(66047));
        tick(8);
        reset_n <= 1'b1;
        bf <= {3'h1, CABLE_ON};
        tick(15);
        expect_lamps(model(3'h0, 1'b0));
        bf <= {3'h1, 2'h1};
        tick(15);
        expect_lamps(model(3'h0, 1'b0));
        bf <= '0;
        tf <= 3'h0;
        ps <= 2'b01;
        tick(ST - 5);
        expect_lamps(model(3'h0, 1'b1));
        tick(20);
        for (int i = 0; i < 12; i++) begin
            vf <= (i == 0) ? 5'h08 : 5'($urandom);
            bf <= {(i % 2 == 0) ? 3'($urandom % 4) : 3'(5 + $urandom % 3), 2'($urandom)};
            tf <= 3'($urandom);
            tick(15);
            expect_lamps(model(3'h0, 1'b0));
        end
        chk(n_prompt, 1);
        for (int h = 4; h <= 6; h += 2) begin
            bus(1'b1, FLASH_OFFSET, h);
            bf <= {INSUL_FLASH, 2'h0};
            tick(15);
            cnt = 0;
            repeat (2 * h) begin
                @(posedge clock);
                cnt += (lamps.insulation === 1'b1);
            end
            chk(cnt, h);
        end
        bf <= {3'h0, CABLE_ON};
        tick(15);
        quiet <= 3'h7;
        tick(LOSS + 15);
        expect_lamps(model(3'h7, 1'b0));
        quiet <= 3'h0;
        tick(15);
        expect_lamps(model(3'h0, 1'b0));
        bus(1'b0, STATUS_OFFSET, 32'h0);
        chk(q[13:8], 6'h08);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        vf <= '0;
        ps <= 2'b00;
        tick(5);
        expect_lamps(model(3'h0, 1'b0));
        ps <= 2'b10;
        tick(15);
        ps <= 2'b01;
        tick(5);
        vf <= 5'h08;
        tick(15);
        expect_lamps(model(3'h0, 1'b0));
        chk(n_prompt, 2);
        tick(2);
        final_report();
    end
endmodule
